// file: logic/clem_pkg.sv
// clem_pkg: register map, field positions, reset values and counts for the clock-loss emergency monitor
// assumes a 32-bit APB slave clocked by pclk at 50 MHz
package clem_pkg;
  // bus
  localparam int unsigned CLEM_AW = 8;
  localparam logic [CLEM_AW-1:0] CLEM_OFS_CTRL = 8'h00;
  localparam logic [CLEM_AW-1:0] CLEM_OFS_STAT = 8'h04;
  localparam logic [CLEM_AW-1:0] CLEM_OFS_TRAP = 8'h08;
  localparam logic [CLEM_AW-1:0] CLEM_OFS_MASK = 8'h0c;
  localparam logic [CLEM_AW-1:0] CLEM_OFS_SCLR = 8'h10;
  // control register fields
  localparam int unsigned CLEM_CTRL_LOCK_EMERG_EN = 0;
  localparam logic CLEM_CTRL_RST = 1'b0;
  // status register fields
  localparam int unsigned CLEM_STAT_EXT_VALID = 0;
  localparam int unsigned CLEM_STAT_VCO_LOCKED = 1;
  localparam int unsigned CLEM_STAT_IN_DISC = 2;
  localparam int unsigned CLEM_STAT_ON_BACKUP = 3;
  // trap and mask register fields
  localparam int unsigned CLEM_NTRAP = 2;
  localparam int unsigned CLEM_TRAP_CLK_EMERG = 0;
  localparam int unsigned CLEM_TRAP_LOSS_LOCK = 1;
  localparam logic [CLEM_NTRAP-1:0] CLEM_MASK_RST = 2'h0;
  // status clear register fields (write one)
  localparam int unsigned CLEM_SCLR_IN_DISC = 0;
  localparam int unsigned CLEM_SCLR_BACKUP = 1;
  // watchdog: reference edges without a monitored edge at which the valid flag clears
  localparam int unsigned CLEM_CW = 8;
  localparam logic [CLEM_CW-1:0] CLEM_OWD_REF_EDGES = 8'h04;
  // lock detector: phase tolerance in pclk cycles, periods to lock and to lose lock
  localparam logic [CLEM_CW-1:0] CLEM_PHASE_TOL = 8'h02;
  localparam logic [CLEM_CW-1:0] CLEM_LOCK_PERIODS = 8'h08;
  localparam logic [CLEM_CW-1:0] CLEM_LOSS_PERIODS = 8'h03;
  localparam logic [CLEM_CW-1:0] CLEM_CNT_MAX = 8'hff;
endpackage

// file: logic/clem_ext_clock_watchdog.sv
// clem_ext_clock_watchdog: clock-presence check of the oscillator input pin against the low-power reference
// assumes both inputs are levels synchronous to pclk
`timescale 1ns/10ps
module clem_ext_clock_watchdog
  import clem_pkg::*;
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // monitored and reference clocks
  input wire logic oscillator_input_pin,
  input wire logic low_power_oscillator,
  // result
  output logic ext_clock_valid_flag
);
  logic osc_d_r, osc_d_nxt;
  logic ref_d_r, ref_d_nxt;
  logic [CLEM_CW-1:0] miss_r, miss_nxt;
  logic valid_r, valid_nxt;
  logic osc_edge, ref_edge;

  assign osc_edge = oscillator_input_pin & ~osc_d_r;
  assign ref_edge = low_power_oscillator & ~ref_d_r;
  assign ext_clock_valid_flag = valid_r;

  always_comb begin
    osc_d_nxt = oscillator_input_pin;
    ref_d_nxt = low_power_oscillator;
    miss_nxt = miss_r;
    valid_nxt = valid_r;
    if (osc_edge) begin
      miss_nxt = '0;
      valid_nxt = 1'b1;
    end else if (ref_edge) begin
      // count reference edges with no monitored edge
      if (miss_r != CLEM_CNT_MAX) begin
        miss_nxt = miss_r + 8'h01;
      end
      if (miss_r + 8'h01 >= CLEM_OWD_REF_EDGES) begin
        valid_nxt = 1'b0;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      osc_d_r <= 1'b0;
      ref_d_r <= 1'b0;
      miss_r <= '0;
      valid_r <= 1'b0;
    end else begin
      osc_d_r <= osc_d_nxt;
      ref_d_r <= ref_d_nxt;
      miss_r <= miss_nxt;
      valid_r <= valid_nxt;
    end
  end
endmodule

// file: logic/clem_monitor.sv
// clem_monitor: clock-loss watchdog, pll loss-of-lock detector, emergency controls and APB registers
// assumes all inputs synchronous to pclk; zero-wait-state APB slave
`timescale 1ns/10ps
// Notes on behaviour
// - watchdog checks oscillator pin activity against the low-power reference clock
// - external-clock-valid flag is one while the pin toggles
// - no pin edge within the latency window clears the valid flag
// - valid flag falling sets clock-emergency trap and requests emergency clock switch
// - emergency switch selects the wake-up oscillator as system clock
// - clock-loss protection only when system clock comes from the oscillator pin
// - lock detector compares feedback divider phase against vco reference continuously
// - phase within tolerance sets the vco-locked bit
// - phase out of range after latency clears locked bit and sets loss-of-lock trap
// - loss of lock disconnects vco input, holds it, shows disconnected status
// - writing one to clear-disconnect reconnects input and clears disconnected status
// - loss-of-lock emergency response only acts in normal operation mode with the lock emergency enable bit set
// - the watchdog ignores pll lock conditions
module clem_monitor
  import clem_pkg::*;
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [CLEM_AW-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // clock sources and modes
  input wire logic oscillator_input_pin,
  input wire logic low_power_oscillator,
  input wire logic sys_clk_from_osc,
  input wire logic normal_mode,
  input wire logic vco_ref_clk,
  input wire logic fb_div_clk,
  // clock system controls
  output logic main_clock_multiplexer_sel_wakeup,
  output logic vco_input_disconnect,
  output logic ext_clock_valid_flag,
  output logic vco_locked_flag,
  // interrupt
  output logic irq
);
  // bus decode
  logic setup_ph, acc_ph, wr_acc, rd_acc, mapped;
  logic [31:0] rdata_r, rdata_nxt;
  logic [31:0] rd_mux;
  // registers
  logic lock_emerg_en_r, lock_emerg_en_nxt;
  logic [CLEM_NTRAP-1:0] mask_r, mask_nxt;
  logic [CLEM_NTRAP-1:0] trap_r, trap_nxt;
  logic [CLEM_NTRAP-1:0] trap_set;
  logic backup_r, backup_nxt;
  logic disc_r, disc_nxt;
  // watchdog
  logic valid_w, valid_d_r, valid_d_nxt, valid_fall;
  // lock detector
  logic ref_d_r, ref_d_nxt, fb_d_r, fb_d_nxt, ref_edge, fb_edge;
  logic [CLEM_CW-1:0] since_ref_r, since_ref_nxt, since_fb_r, since_fb_nxt;
  logic [CLEM_CW-1:0] good_r, good_nxt, bad_r, bad_nxt;
  logic lag_ok_r, lag_ok_nxt, period_ok;
  logic locked_r, locked_nxt, lock_fall;
  logic sclr_disc, sclr_backup;

  assign setup_ph = psel & ~penable;
  assign acc_ph = psel & penable;
  assign wr_acc = acc_ph & pwrite;
  assign rd_acc = acc_ph & ~pwrite;
  assign mapped = (paddr == CLEM_OFS_CTRL) | (paddr == CLEM_OFS_STAT) | (paddr == CLEM_OFS_TRAP) |
                  (paddr == CLEM_OFS_MASK) | (paddr == CLEM_OFS_SCLR);
  assign pready = 1'b1;
  assign pslverr = acc_ph & ~mapped;
  assign prdata = rdata_r;

  // external clock watchdog, independent of the pll path
  clem_ext_clock_watchdog u_wdt (
    .pclk(pclk),
    .presetn(presetn),
    .oscillator_input_pin(oscillator_input_pin),
    .low_power_oscillator(low_power_oscillator),
    .ext_clock_valid_flag(valid_w)
  );

  assign ext_clock_valid_flag = valid_w;
  assign valid_fall = valid_d_r & ~valid_w;
  assign ref_edge = vco_ref_clk & ~ref_d_r;
  assign fb_edge = fb_div_clk & ~fb_d_r;
  assign period_ok = lag_ok_r | (since_fb_r <= CLEM_PHASE_TOL);
  assign lock_fall = locked_r & ~locked_nxt;
  assign sclr_disc = wr_acc & (paddr == CLEM_OFS_SCLR) & pwdata[CLEM_SCLR_IN_DISC];
  assign sclr_backup = wr_acc & (paddr == CLEM_OFS_SCLR) & pwdata[CLEM_SCLR_BACKUP];

  assign main_clock_multiplexer_sel_wakeup = backup_r;
  assign vco_input_disconnect = disc_r;
  assign vco_locked_flag = locked_r;
  assign irq = |(trap_r & mask_r);

  // read data mux
  always_comb begin
    rd_mux = '0;
    case (paddr)
      CLEM_OFS_CTRL: begin
        rd_mux[CLEM_CTRL_LOCK_EMERG_EN] = lock_emerg_en_r;
      end
      CLEM_OFS_STAT: begin
        rd_mux[CLEM_STAT_EXT_VALID] = valid_w;
        rd_mux[CLEM_STAT_VCO_LOCKED] = locked_r;
        rd_mux[CLEM_STAT_IN_DISC] = disc_r;
        rd_mux[CLEM_STAT_ON_BACKUP] = backup_r;
      end
      CLEM_OFS_TRAP: begin
        rd_mux[CLEM_NTRAP-1:0] = trap_r;
      end
      CLEM_OFS_MASK: begin
        rd_mux[CLEM_NTRAP-1:0] = mask_r;
      end
      default: begin
        rd_mux = '0;
      end
    endcase
  end

  // lock detector: phase check per reference period
  always_comb begin
    ref_d_nxt = vco_ref_clk;
    fb_d_nxt = fb_div_clk;
    since_ref_nxt = (since_ref_r == CLEM_CNT_MAX) ? since_ref_r : since_ref_r + 8'h01;
    since_fb_nxt = (since_fb_r == CLEM_CNT_MAX) ? since_fb_r : since_fb_r + 8'h01;
    lag_ok_nxt = lag_ok_r;
    good_nxt = good_r;
    bad_nxt = bad_r;
    locked_nxt = locked_r;
    if (fb_edge) begin
      since_fb_nxt = '0;
      if (since_ref_r <= CLEM_PHASE_TOL) begin
        lag_ok_nxt = 1'b1;
      end
    end
    if (ref_edge) begin
      since_ref_nxt = '0;
      lag_ok_nxt = fb_edge;
      if (period_ok) begin
        bad_nxt = '0;
        good_nxt = (good_r == CLEM_CNT_MAX) ? good_r : good_r + 8'h01;
        if (good_r + 8'h01 >= CLEM_LOCK_PERIODS) begin
          locked_nxt = 1'b1;
        end
      end else begin
        good_nxt = '0;
        bad_nxt = (bad_r == CLEM_CNT_MAX) ? bad_r : bad_r + 8'h01;
        if (bad_r + 8'h01 >= CLEM_LOSS_PERIODS) begin
          locked_nxt = 1'b0;
        end
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ref_d_r <= 1'b0;
      fb_d_r <= 1'b0;
      since_ref_r <= CLEM_CNT_MAX;
      since_fb_r <= CLEM_CNT_MAX;
      lag_ok_r <= 1'b0;
      good_r <= '0;
      bad_r <= '0;
      locked_r <= 1'b0;
    end else begin
      ref_d_r <= ref_d_nxt;
      fb_d_r <= fb_d_nxt;
      since_ref_r <= since_ref_nxt;
      since_fb_r <= since_fb_nxt;
      lag_ok_r <= lag_ok_nxt;
      good_r <= good_nxt;
      bad_r <= bad_nxt;
      locked_r <= locked_nxt;
    end
  end

  // emergency actions, traps and software registers
  always_comb begin
    valid_d_nxt = valid_w;
    trap_set = '0;
    backup_nxt = backup_r;
    disc_nxt = disc_r;
    lock_emerg_en_nxt = lock_emerg_en_r;
    mask_nxt = mask_r;
    rdata_nxt = rdata_r;
    if (valid_fall && sys_clk_from_osc) begin
      trap_set[CLEM_TRAP_CLK_EMERG] = 1'b1;
    end
    if (sclr_backup) begin
      backup_nxt = 1'b0;
    end
    if (valid_fall && sys_clk_from_osc) begin
      backup_nxt = 1'b1;
    end
    if (sclr_disc) begin
      disc_nxt = 1'b0;
    end
    if (lock_fall && normal_mode && lock_emerg_en_r) begin
      trap_set[CLEM_TRAP_LOSS_LOCK] = 1'b1;
      disc_nxt = 1'b1;
    end
    // a read of the trap register clears it; a new event in that cycle wins
    trap_nxt = trap_r;
    if (rd_acc && (paddr == CLEM_OFS_TRAP)) begin
      trap_nxt = '0;
    end
    trap_nxt = trap_nxt | trap_set;
    if (wr_acc && (paddr == CLEM_OFS_CTRL)) begin
      lock_emerg_en_nxt = pwdata[CLEM_CTRL_LOCK_EMERG_EN];
    end
    if (wr_acc && (paddr == CLEM_OFS_MASK)) begin
      mask_nxt = pwdata[CLEM_NTRAP-1:0];
    end
    if (setup_ph && !pwrite) begin
      rdata_nxt = rd_mux;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      valid_d_r <= 1'b0;
      trap_r <= '0;
      backup_r <= 1'b0;
      disc_r <= 1'b0;
      lock_emerg_en_r <= CLEM_CTRL_RST;
      mask_r <= CLEM_MASK_RST;
      rdata_r <= '0;
    end else begin
      valid_d_r <= valid_d_nxt;
      trap_r <= trap_nxt;
      backup_r <= backup_nxt;
      disc_r <= disc_nxt;
      lock_emerg_en_r <= lock_emerg_en_nxt;
      mask_r <= mask_nxt;
      rdata_r <= rdata_nxt;
    end
  end
endmodule

// file: verif/clem_osc_model.sv
// clem_osc_model: external clock source at the oscillator input pin
// assumes pclk is faster than the oscillator; a stopped source rests low
`timescale 1ns/10ps
module clem_osc_model (
  // clock
  input wire logic pclk,
  // control
  input wire logic run,
  input wire logic [1:0] half,
  // pin
  output logic pin
);
  logic [1:0] cnt_r = 2'h0;
  initial pin = 1'b0;
  always @(posedge pclk) begin
    if (!run) begin
      pin <= 1'b0;
      cnt_r <= 2'h0;
    end else if (cnt_r >= half) begin
      pin <= ~pin;
      cnt_r <= 2'h0;
    end else begin
      cnt_r <= cnt_r + 2'h1;
    end
  end
endmodule

// file: verif/clem_monitor_properties.sv
// clem_monitor_checker: concurrent checks on the ports of clem_monitor
// assumes one pclk domain and presetn async active low
`timescale 1ns/10ps
module clem_monitor_checker
  import clem_pkg::*;
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [CLEM_AW-1:0] paddr,
  input wire logic [31:0] pwdata,
  // sources and modes
  input wire logic oscillator_input_pin,
  input wire logic low_power_oscillator,
  input wire logic sys_clk_from_osc,
  input wire logic normal_mode,
  // results
  input wire logic main_clock_multiplexer_sel_wakeup,
  input wire logic vco_input_disconnect,
  input wire logic ext_clock_valid_flag,
  input wire logic vco_locked_flag
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic wr, clr_disc, clr_bkp, en_r, en_nxt, pin_d_r, lpo_d_r;
  logic [2:0] cnt_r, cnt_nxt;
  assign wr = psel && penable && pwrite;
  assign clr_disc = wr && paddr == CLEM_OFS_SCLR && pwdata[CLEM_SCLR_IN_DISC];
  assign clr_bkp = wr && paddr == CLEM_OFS_SCLR && pwdata[CLEM_SCLR_BACKUP];
  // control shadow and reference edges since the last pin rise
  always_comb begin
    en_nxt = en_r;
    cnt_nxt = cnt_r;
    if (wr && paddr == CLEM_OFS_CTRL) begin
      en_nxt = pwdata[CLEM_CTRL_LOCK_EMERG_EN];
    end
    if (oscillator_input_pin && !pin_d_r) begin
      cnt_nxt = 3'h0;
    end else if (low_power_oscillator && !lpo_d_r && cnt_r != 3'h7) begin
      cnt_nxt = cnt_r + 3'h1;
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      en_r <= 1'b0;
      cnt_r <= 3'h0;
      pin_d_r <= 1'b0;
      lpo_d_r <= 1'b0;
    end else begin
      en_r <= en_nxt;
      cnt_r <= cnt_nxt;
      pin_d_r <= oscillator_input_pin;
      lpo_d_r <= low_power_oscillator;
    end
  end
  sequence s_osc_lost;
    $fell(ext_clock_valid_flag) ##0 sys_clk_from_osc;
  endsequence
  sequence s_lock_lost;
    $fell(vco_locked_flag) ##0 ($past(normal_mode) && $past(en_r));
  endsequence
  a_valid_rise: assert property ($rose(oscillator_input_pin) |-> ##[1:3] ext_clock_valid_flag)
    else $error("valid flag not set by pin edge");
  a_valid_loss: assert property (cnt_r >= 3'h4 |-> !ext_clock_valid_flag)
    else $error("valid flag kept without pin edges");
  a_switch_on_loss: assert property (s_osc_lost |-> ##[1:3] main_clock_multiplexer_sel_wakeup)
    else $error("no backup switch after clock loss");
  a_switch_cause: assert property ($rose(main_clock_multiplexer_sel_wakeup) |->
    $past(!ext_clock_valid_flag) && $past(sys_clk_from_osc))
    else $error("backup switch without clock loss");
  a_switch_hold: assert property (main_clock_multiplexer_sel_wakeup && !clr_bkp |=>
    main_clock_multiplexer_sel_wakeup)
    else $error("backup source dropped");
  a_disc_on_loss: assert property (s_lock_lost |-> vco_input_disconnect)
    else $error("no disconnect on lock loss");
  a_disc_cause: assert property ($rose(vco_input_disconnect) |-> s_lock_lost)
    else $error("disconnect without enabled lock loss");
  a_disc_hold: assert property (vco_input_disconnect && !clr_disc |=> vco_input_disconnect)
    else $error("disconnect released early");
  a_disc_clear: assert property (clr_disc && !vco_locked_flag |=> !vco_input_disconnect)
    else $error("disconnect not cleared");
endmodule

// file: verif/tb_clem_monitor.sv
// tb_clem_monitor: self-checking bench for clem_monitor
// assumes clem_pkg, clem_osc_model and clem_monitor_checker compiled before it
`timescale 1ns/10ps
module tb_clem_monitor;
  import clem_pkg::*;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [CLEM_AW-1:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd, lfsr = 32'hdb0f;
  logic pready, pslverr, err, osc_pin, lpo = 1'b0, sys_osc = 1'b0, norm = 1'b0, run = 1'b0;
  logic ref_clk = 1'b0, fb_clk = 1'b0, sel_wu, disc, valid, locked, irq;
  logic [1:0] half = 2'h1;
  logic [3:0] ph = 4'h0, shift = 4'h8, phs;
  int n_mismatch = 0, checked = 0;
  always #10 pclk = ~pclk;
  assign phs = ph + shift;
  always @(posedge pclk) begin
    ph <= ph + 4'h1;
    lpo <= ph[2];
    ref_clk <= ph[3];
    fb_clk <= phs[3];
  end
  clem_osc_model i_clem_osc_model (.pclk(pclk), .run(run), .half(half), .pin(osc_pin));
  clem_monitor i_clem_monitor (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .oscillator_input_pin(osc_pin), .low_power_oscillator(lpo), .sys_clk_from_osc(sys_osc),
    .normal_mode(norm), .vco_ref_clk(ref_clk), .fb_div_clk(fb_clk), .main_clock_multiplexer_sel_wakeup(sel_wu),
    .vco_input_disconnect(disc), .ext_clock_valid_flag(valid), .vco_locked_flag(locked), .irq(irq));
  function automatic logic [31:0] lfsr_next(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  function automatic logic [31:0] exp_stat(input logic v, input logic l, input logic d, input logic b);
    return {28'h0, b, d, l, v};
  endfunction
  task automatic close_out();
    $display("checked %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic apb(input logic w, input logic [CLEM_AW-1:0] a, input logic [31:0] d);
    int i;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (i = 0; i < 16; i++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (i == 16) begin
      chk("pready", 32'h1, 32'h0);
      close_out();
    end
    @(posedge pclk);
  endtask
  task automatic rdchk(input string what, input logic [CLEM_AW-1:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(what, exp, rd);
  endtask
  task automatic wait_for(input int s, input logic v);
    int i;
    for (i = 0; i < 600; i++) begin
      @(posedge pclk);
      if ((s == 0 ? valid : locked) === v) break;
    end
    if (i == 600) begin
      chk("wait", 32'h1, 32'h0);
      close_out();
    end
  endtask
  initial begin
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rdchk("ctrl", CLEM_OFS_CTRL, 32'h0);
    rdchk("stat", CLEM_OFS_STAT, 32'h0);
    rdchk("trap", CLEM_OFS_TRAP, 32'h0);
    chk("pslverr", 32'h0, {31'h0, err});
    rdchk("unmapped", 8'h14, 32'h0);
    chk("pslverr", 32'h1, {31'h0, err});
    for (int k = 0; k < 4; k++) begin
      lfsr = lfsr_next(lfsr);
      apb(1'b1, CLEM_OFS_MASK, lfsr);
      rdchk("mask", CLEM_OFS_MASK, lfsr & 32'h3);
    end
    apb(1'b1, CLEM_OFS_MASK, 32'h3);
    $display("test registers done");
    half <= {1'b0, lfsr[0]} + 2'h1;
    run <= 1'b1;
    sys_osc <= 1'b1;
    wait_for(0, 1'b1);
    run <= 1'b0;
    wait_for(0, 1'b0);
    repeat (4) @(posedge pclk);
    chk("irq", 32'h1, {31'h0, irq});
    chk("sel_wu", 32'h1, {31'h0, sel_wu});
    run <= 1'b1;
    wait_for(0, 1'b1);
    rdchk("stat", CLEM_OFS_STAT, exp_stat(1'b1, 1'b0, 1'b0, 1'b1));
    rdchk("trap", CLEM_OFS_TRAP, 32'h1);
    rdchk("trap", CLEM_OFS_TRAP, 32'h0);
    apb(1'b1, CLEM_OFS_SCLR, 32'h2);
    sys_osc <= 1'b0;
    run <= 1'b0;
    wait_for(0, 1'b0);
    repeat (4) @(posedge pclk);
    rdchk("trap", CLEM_OFS_TRAP, 32'h0);
    chk("sel_wu", 32'h0, {31'h0, sel_wu});
    run <= 1'b1;
    $display("test clock loss done");
    for (int k = 1; k < 4; k++) begin
      apb(1'b1, CLEM_OFS_CTRL, {31'h0, k[1]});
      norm <= k[0];
      shift <= 4'h0;
      wait_for(1, 1'b1);
      shift <= 4'h8;
      wait_for(1, 1'b0);
      repeat (20) @(posedge pclk);
      chk("irq", {31'h0, k == 3}, {31'h0, irq});
      chk("disc", {31'h0, k == 3}, {31'h0, disc});
      rdchk("trap", CLEM_OFS_TRAP, {30'h0, k == 3, 1'b0});
      rdchk("stat", CLEM_OFS_STAT, exp_stat(1'b1, 1'b0, k == 3, 1'b0));
      apb(1'b1, CLEM_OFS_SCLR, 32'h1);
      rdchk("stat", CLEM_OFS_STAT, exp_stat(1'b1, 1'b0, 1'b0, 1'b0));
    end
    $display("test lock loss done");
    close_out();
  end
endmodule
bind clem_monitor clem_monitor_checker i_clem_monitor_checker (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .oscillator_input_pin(oscillator_input_pin), .low_power_oscillator(low_power_oscillator),
  .sys_clk_from_osc(sys_clk_from_osc), .normal_mode(normal_mode),
  .main_clock_multiplexer_sel_wakeup(main_clock_multiplexer_sel_wakeup),
  .vco_input_disconnect(vco_input_disconnect), .ext_clock_valid_flag(ext_clock_valid_flag),
  .vco_locked_flag(vco_locked_flag));
